// File: lsi_consts.svh
`ifndef LSI_CONSTS_SVH
`define LSI_CONSTS_SVH

// Register offsets on the serial control port
`define LSI_ADDR_FAULT_MASK_THREE 7'h58
`define LSI_ADDR_EVENT_FLAGS      7'h5A
`define LSI_ADDR_EVENT_MASK       7'h5E

// Reset values
`define LSI_RST_FAULT_MASK_THREE  8'hBC
`define LSI_RST_EVENT_FLAGS       8'h00
`define LSI_RST_EVENT_MASK        8'hCC

// Implemented bits; the rest are reserved and read zero
`define LSI_USED_FAULT_MASK_THREE 8'hBC
`define LSI_USED_EVENT            8'hCC

// Field positions, third fault mask
`define LSI_BIT_SERIAL_FAULT      7
`define LSI_BIT_FAILSAFE          5
`define LSI_BIT_FRAME_CHECK       4
`define LSI_BIT_REGULATOR_SHORT   3
`define LSI_BIT_RESTART_LIMIT     2

// Field positions, event flags and event mask
`define LSI_BIT_BUS_WAKE          7
`define LSI_BIT_BUS_DTO           6
`define LSI_BIT_SW_OVERCURRENT    3
`define LSI_BIT_SW_OPEN_LOAD      2

// Serial frame shape
`define LSI_CMD_BITS              8
`define LSI_FRAME_BITS            16

// Timing
`define LSI_REF_CLK_MHZ           50
`define LSI_MODE_CHANGE_TIME_US   200
`define LSI_NORMAL_INIT_TIME_US   50

`endif

// File: lsi_pkg.sv
`default_nettype none

package lsi_pkg;

   typedef logic [7:0] lsi_byte_t;

   typedef enum logic [1:0] {
      LSI_SLEEP,
      LSI_STANDBY,
      LSI_NORMAL_INIT,
      LSI_NORMAL
   } lsi_mode_e;

   typedef struct packed {
      logic [6:0] addr;
      logic       write;
   } lsi_cmd_s;

   typedef struct packed {
      logic bus_wake;
      logic bus_dto;
      logic sw_oc;
      logic sw_ol;
   } lsi_events_s;

   typedef struct packed {
      logic        sck;
      logic        cs_n;
      logic        sdi;
      lsi_events_s ev;
      logic        supply_uv;
      logic        below_por;
      logic        lin_rx;
   } lsi_pins_s;

endpackage : lsi_pkg

`default_nettype wire

// File: lsi_sync.sv
`default_nettype none

module lsi_sync #(
   parameter int                 WIDTH   = 1,
   parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Pins and synchronised copies
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (rst) begin
            meta_q[i]   <= RST_VAL[i];
            sync_out[i] <= RST_VAL[i];
         end else begin
            meta_q[i]   <= async_in[i];
            sync_out[i] <= meta_q[i];
         end
      end
   end

endmodule : lsi_sync

`default_nettype wire

// File: lsi_top.sv
// What this block does
// - Third mask bit 7 allows serial-fault interrupt
// - Third mask bit 5 failsafe; bit 6 zero
// - Third mask bit 4 gates frame-check interrupt
// - Third mask bit 3 gates regulator short
// - Third mask bit 2 restart limit; 1-0 zero
// - Event flag register at 0x5A, resets zero
// - Bus wake, dominant timeout flags, write-one-clear
// - Switch overcurrent, open load flags; reserved zero
// - Event mask at 0x5E resets 0xCC
// - Event mask bits 3,2 gate switch flags
// - Undefined addresses up to 0x7F reserved
// - Receive output held recessive while changing state
// - Normal entry passes an initialisation period
// - Supply undervoltage drives receive output low
// - Below power-on threshold resets all but the pin synchronisers and their edge-detect copy
// - Enable pin serves as interrupt output

`default_nettype none

`include "lsi_consts.svh"

module lsi_top
   import lsi_pkg::*;
#(
   parameter int unsigned MODE_CHANGE_CYC =
      `LSI_MODE_CHANGE_TIME_US * `LSI_REF_CLK_MHZ,
   parameter int unsigned NORMAL_INIT_CYC =
      `LSI_NORMAL_INIT_TIME_US * `LSI_REF_CLK_MHZ
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // Serial control port
   input  wire logic       spi_sck,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_sdi,
   output logic            spi_sdo,
   output logic            spi_sdo_oe,
   // Event pins from the analog blocks
   input  wire logic       ev_bus_wake,
   input  wire logic       ev_bus_dto,
   input  wire logic       ev_sw_oc,
   input  wire logic       ev_sw_ol,
   // Flags of the third fault register, same clock
   input  wire lsi_byte_t  fault_flags_three,
   // Supply monitors
   input  wire logic       supply_uv,
   input  wire logic       supply_below_por,
   // Operating state requests, same clock
   input  wire logic       mode_req_valid,
   input  wire lsi_mode_e  mode_req,
   // Bus receiver and host pins
   input  wire logic       lin_rx_in,
   output logic            rxd_out,
   output logic            host_irq_out_n,
   // Status
   output lsi_mode_e       op_mode,
   output logic            normal_ready,
   output logic            serial_frame_error
);

   localparam int CHG_W  = $clog2(MODE_CHANGE_CYC + 1);
   localparam int INIT_W = $clog2(NORMAL_INIT_CYC + 1);

   // Idle pin levels; releasing reset must not look like a select or bus edge
   localparam lsi_pins_s PINS_IDLE = 10'h101;

   // Synchronised pins
   lsi_pins_s   pins_raw;
   lsi_pins_s   pins_s;
   lsi_pins_s   pins_d_q;
   logic        core_rst;

   // Serial port state
   logic [4:0]  bit_cnt_q;
   logic [15:0] shift_in_q;
   lsi_byte_t   shift_out_q;
   lsi_cmd_s    cmd_q;
   logic        sck_rise;
   logic        sck_fall;
   logic        cs_fall;
   logic        cs_rise;
   logic        frame_active;
   logic        frame_done;
   logic        wr_en;
   lsi_byte_t   wr_data;

   // Registers
   lsi_byte_t   fault_mask_three_q;
   lsi_byte_t   event_flags_q;
   lsi_byte_t   event_flags_d;
   lsi_byte_t   event_mask_q;
   lsi_byte_t   event_set;
   lsi_events_s ev_rise;
   logic        irq_pending;

   // Operating state
   lsi_mode_e   mode_q;
   logic [CHG_W-1:0]  chg_cnt_q;
   logic [INIT_W-1:0] init_cnt_q;
   logic        uv_rise;

   function automatic lsi_byte_t reg_read(input logic [6:0] addr,
                                          input lsi_byte_t  m3,
                                          input lsi_byte_t  fl,
                                          input lsi_byte_t  mk);
      lsi_byte_t val;
      case (addr)
         `LSI_ADDR_FAULT_MASK_THREE: val = m3 & `LSI_USED_FAULT_MASK_THREE;
         `LSI_ADDR_EVENT_FLAGS:      val = fl & `LSI_USED_EVENT;
         `LSI_ADDR_EVENT_MASK:       val = mk & `LSI_USED_EVENT;
         default:                    val = 8'h00;
      endcase
      return val;
   endfunction : reg_read

   function automatic logic reg_hit(input logic [6:0] addr, input logic [6:0] target);
      return addr == target;
   endfunction : reg_hit

   assign pins_raw = '{sck:       spi_sck,
                       cs_n:      spi_cs_n,
                       sdi:       spi_sdi,
                       ev:        '{bus_wake: ev_bus_wake,
                                    bus_dto:  ev_bus_dto,
                                    sw_oc:    ev_sw_oc,
                                    sw_ol:    ev_sw_ol},
                       supply_uv: supply_uv,
                       below_por: supply_below_por,
                       lin_rx:    lin_lin_rx_fix(lin_rx_in)};

   function automatic logic lin_lin_rx_fix(input logic v);
      return v;
   endfunction : lin_lin_rx_fix

   lsi_sync #(
      .WIDTH   ($bits(lsi_pins_s)),
      .RST_VAL (PINS_IDLE)
   ) u_pin_sync (
      .clk      (ref_clk),
      .rst      (rst),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   // Brownout above the threshold resets nothing, though undervoltage still forces standby
   assign core_rst = rst | pins_s.below_por;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins_d_q <= PINS_IDLE;
      end else begin
         pins_d_q <= pins_s;
      end
   end

   assign sck_rise     = pins_s.sck & ~pins_d_q.sck;
   assign sck_fall     = ~pins_s.sck & pins_d_q.sck;
   assign cs_fall      = ~pins_s.cs_n & pins_d_q.cs_n;
   assign cs_rise      = pins_s.cs_n & ~pins_d_q.cs_n;
   assign frame_active = ~pins_s.cs_n;
   assign ev_rise      = pins_s.ev & ~pins_d_q.ev;
   assign uv_rise      = pins_s.supply_uv & ~pins_d_q.supply_uv;

   // Writes land only when a whole frame closes, so a torn frame changes nothing
   assign frame_done = cs_rise && (bit_cnt_q == 5'(`LSI_FRAME_BITS));
   assign wr_en      = frame_done && cmd_q.write;
   assign wr_data    = shift_in_q[7:0];

   // Serial receive side
   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         bit_cnt_q  <= 5'h00;
         shift_in_q <= 16'h0000;
         cmd_q      <= '0;
      end else if (cs_fall) begin
         bit_cnt_q  <= 5'h00;
      end else if (frame_active && sck_rise) begin
         shift_in_q <= {shift_in_q[14:0], pins_s.sdi};
         if (bit_cnt_q != 5'h1F) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
         if (bit_cnt_q == 5'(`LSI_CMD_BITS - 1)) begin
            cmd_q <= {shift_in_q[6:0], pins_s.sdi};
         end
      end
   end

   // Serial transmit side: flags first, addressed register second
   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         shift_out_q <= 8'h00;
         spi_sdo     <= 1'b0;
         spi_sdo_oe  <= 1'b0;
      end else if (cs_fall) begin
         shift_out_q <= {event_flags_q[6:0], 1'b0};
         spi_sdo     <= event_flags_q[7];
         spi_sdo_oe  <= 1'b1;
      end else if (cs_rise) begin
         spi_sdo     <= 1'b0;
         spi_sdo_oe  <= 1'b0;
      end else if (frame_active && sck_rise
                   && bit_cnt_q == 5'(`LSI_CMD_BITS - 1)) begin
         shift_out_q <= reg_read(shift_in_q[6:0], fault_mask_three_q,
                                 event_flags_q, event_mask_q);
      end else if (frame_active && sck_fall) begin
         spi_sdo     <= shift_out_q[7];
         shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         serial_frame_error <= 1'b0;
      end else begin
         serial_frame_error <= cs_rise && (bit_cnt_q != 5'(`LSI_FRAME_BITS));
      end
   end

   // Third fault mask
   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         fault_mask_three_q <= `LSI_RST_FAULT_MASK_THREE;
      end else if (wr_en && reg_hit(cmd_q.addr, `LSI_ADDR_FAULT_MASK_THREE)) begin
         fault_mask_three_q <= wr_data & `LSI_USED_FAULT_MASK_THREE;
      end
   end

   // Event mask
   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         event_mask_q <= `LSI_RST_EVENT_MASK;
      end else if (wr_en && reg_hit(cmd_q.addr, `LSI_ADDR_EVENT_MASK)) begin
         event_mask_q <= wr_data & `LSI_USED_EVENT;
      end
   end

   // Event flags: set beats a same-cycle clear, and the mask plays no part
   always_comb begin
      event_set = 8'h00;
      event_set[`LSI_BIT_BUS_WAKE]       = ev_rise.bus_wake;
      event_set[`LSI_BIT_BUS_DTO]        = ev_rise.bus_dto;
      event_set[`LSI_BIT_SW_OVERCURRENT] = ev_rise.sw_oc;
      event_set[`LSI_BIT_SW_OPEN_LOAD]   = ev_rise.sw_ol;
      event_flags_d = event_flags_q;
      if (wr_en && reg_hit(cmd_q.addr, `LSI_ADDR_EVENT_FLAGS)) begin
         event_flags_d = event_flags_q & ~wr_data;
      end
      event_flags_d = (event_flags_d | event_set) & `LSI_USED_EVENT;
   end

   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         event_flags_q <= `LSI_RST_EVENT_FLAGS;
      end else begin
         event_flags_q <= event_flags_d;
      end
   end

   // Interrupt pin, active low
   assign irq_pending = |(event_flags_q & event_mask_q)
                      | |(fault_flags_three & fault_mask_three_q
                          & `LSI_USED_FAULT_MASK_THREE);

   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         host_irq_out_n <= 1'b1;
      end else begin
         host_irq_out_n <= ~irq_pending;
      end
   end

   // Operating state
   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         mode_q     <= LSI_STANDBY;
         chg_cnt_q  <= '0;
         init_cnt_q <= '0;
      end else begin
         if (chg_cnt_q != '0) begin
            chg_cnt_q <= chg_cnt_q - 1'b1;
         end
         if (uv_rise) begin
            mode_q    <= LSI_STANDBY;
            chg_cnt_q <= CHG_W'(MODE_CHANGE_CYC);
         end else if (mode_req_valid && mode_req != mode_q) begin
            chg_cnt_q <= CHG_W'(MODE_CHANGE_CYC);
            if (mode_req == LSI_NORMAL || mode_req == LSI_NORMAL_INIT) begin
               if (mode_q != LSI_NORMAL_INIT) begin
                  mode_q     <= LSI_NORMAL_INIT;
                  init_cnt_q <= INIT_W'(NORMAL_INIT_CYC);
               end
            end else begin
               mode_q <= mode_req;
            end
         end else if (mode_q == LSI_NORMAL_INIT) begin
            if (init_cnt_q == '0) begin
               mode_q <= LSI_NORMAL;
            end else begin
               init_cnt_q <= init_cnt_q - 1'b1;
            end
         end
      end
   end

   // Receive output; parked recessive while receivers switch over
   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         rxd_out <= 1'b1;
      end else if (pins_s.supply_uv) begin
         rxd_out <= 1'b0;
      end else if (chg_cnt_q != '0) begin
         rxd_out <= 1'b1;
      end else begin
         case (mode_q)
            LSI_NORMAL,
            LSI_NORMAL_INIT: rxd_out <= pins_s.lin_rx;
            LSI_SLEEP,
            LSI_STANDBY:     rxd_out <= ~event_flags_q[`LSI_BIT_BUS_WAKE];
            default:         rxd_out <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (core_rst) begin
         op_mode      <= LSI_STANDBY;
         normal_ready <= 1'b0;
      end else begin
         op_mode      <= mode_q;
         normal_ready <= (mode_q == LSI_NORMAL);
      end
   end

endmodule : lsi_top

`default_nettype wire

// File: lsi_checker.sv
`default_nettype none

module lsi_checker
   import lsi_pkg::*;
#(
   parameter int unsigned NORMAL_INIT_CYC = 2500
) (
   // Clock and reset
   input wire logic      ref_clk,
   input wire logic      rst,
   // Inputs watched
   input wire logic      supply_uv,
   input wire logic      supply_below_por,
   input wire logic      mode_req_valid,
   input wire lsi_mode_e mode_req,
   // Outputs watched
   input wire logic      rxd_out,
   input wire logic      host_irq_out_n,
   input wire lsi_mode_e op_mode,
   input wire logic      normal_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Counts cycles spent initialising; too long for a repetition
   logic [31:0] init_cnt_q;
   logic [31:0] init_cnt_d;
   assign init_cnt_d = (op_mode == LSI_NORMAL_INIT) ? init_cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         init_cnt_q <= 32'h0;
      end else begin
         init_cnt_q <= init_cnt_d;
      end
   end

   sequence s_init_done;
      op_mode == LSI_NORMAL && $past(op_mode) == LSI_NORMAL_INIT;
   endsequence
   sequence s_uv_held;
      supply_uv[*4];
   endsequence
   sequence s_por_held;
      supply_below_por[*4];
   endsequence

   chk_init_entry: assert property (
      mode_req_valid && mode_req == LSI_NORMAL && op_mode != LSI_NORMAL && !supply_uv
      && !supply_below_por |-> ##2 op_mode == LSI_NORMAL_INIT)
      else $error("normal request did not start initialisation");
   chk_init_length: assert property (
      s_init_done |-> init_cnt_q == NORMAL_INIT_CYC + 1)
      else $error("initialisation period has wrong length");
   chk_ready_mode: assert property (
      normal_ready == (op_mode == LSI_NORMAL))
      else $error("ready flag disagrees with mode");
   chk_uv_rxd_low: assert property (
      s_uv_held |-> !rxd_out)
      else $error("receive output not low in undervoltage");
   chk_uv_standby: assert property (
      s_uv_held |=> op_mode == LSI_STANDBY)
      else $error("undervoltage did not give standby");
   chk_rxd_settle: assert property (
      $changed(op_mode) && !supply_uv |=> rxd_out[*3])
      else $error("receive output not parked after mode change");
   chk_por_state: assert property (
      s_por_held |-> op_mode == LSI_STANDBY && !normal_ready)
      else $error("power-on reset did not reset mode");
   chk_por_pins: assert property (
      s_por_held |-> host_irq_out_n && rxd_out)
      else $error("power-on reset did not park pins");
endmodule : lsi_checker

bind lsi_top lsi_checker #(
   .NORMAL_INIT_CYC(NORMAL_INIT_CYC)
) u_lsi_checker (
   .ref_clk         (ref_clk),
   .rst             (rst),
   .supply_uv       (supply_uv),
   .supply_below_por(supply_below_por),
   .mode_req_valid  (mode_req_valid),
   .mode_req        (mode_req),
   .rxd_out         (rxd_out),
   .host_irq_out_n  (host_irq_out_n),
   .op_mode         (op_mode),
   .normal_ready    (normal_ready)
);

`default_nettype wire

// File: lsi_host_model.sv
`default_nettype none

module lsi_host_model (
   // Clock
   input  wire logic ref_clk,
   // Serial port toward the device
   output logic      spi_sck,
   output logic      spi_cs_n,
   output logic      spi_sdi,
   input  wire logic spi_sdo
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      spi_sck  = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b0;
   end

   // Four clocks a half bit gives the 160 ns link period
   task automatic half_bit();
      repeat (4) @(posedge ref_clk);
   endtask : half_bit

   // Link clock stands still outside frames
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge ref_clk);
      spi_cs_n <= 1'b0;
      spi_sdi  <= tx[15];
      half_bit();
      for (int i = 0; i < nbits; i++) begin
         rx = {rx[14:0], spi_sdo};
         spi_sck <= 1'b1;
         half_bit();
         spi_sck <= 1'b0;
         spi_sdi <= (i < 15) ? tx[14-i] : ~tx[0];
         half_bit();
      end
      spi_cs_n <= 1'b1;
      // Released data line must not keep the last bit
      spi_sdi  <= ~spi_sdi;
      repeat (8) @(posedge ref_clk);
   endtask : xfer
endmodule : lsi_host_model

`default_nettype wire

// File: lsi_top_tb_top.sv
`default_nettype none

module lsi_top_tb_top;
   import lsi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic      ref_clk = 1'b0;
   logic      rst = 1'b1;
   logic      sck, cs_n, sdi, sdo, sdo_oe, rxd, irq_n, ready, ferr;
   logic      uv = 1'b0;
   logic      por = 1'b0;
   logic      mreq_v = 1'b0;
   lsi_mode_e mreq = LSI_SLEEP;
   lsi_mode_e mode;
   logic [3:0] ev = 4'h0;
   lsi_byte_t fault3 = 8'h00;
   logic      lrx = 1'b1;
   logic      oe_seen = 1'b0;
   int        ferr_seen = 0;
   int        fail_count = 0;
   int        comparisons = 0;

   always #10 ref_clk = ~ref_clk;

   // Error pulses last one cycle, so they are counted as they pass
   always @(posedge ref_clk) begin
      if (ferr === 1'b1) ferr_seen <= ferr_seen + 1;
      if (sdo_oe === 1'b1) oe_seen <= 1'b1;
   end

   lsi_top #(.MODE_CHANGE_CYC(20), .NORMAL_INIT_CYC(10)) u_lsi_top (
      .ref_clk(ref_clk), .rst(rst), .spi_sck(sck), .spi_cs_n(cs_n), .spi_sdi(sdi),
      .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .ev_bus_wake(ev[3]), .ev_bus_dto(ev[2]),
      .ev_sw_oc(ev[1]), .ev_sw_ol(ev[0]), .fault_flags_three(fault3), .supply_uv(uv),
      .supply_below_por(por), .mode_req_valid(mreq_v), .mode_req(mreq),
      .lin_rx_in(lrx), .rxd_out(rxd), .host_irq_out_n(irq_n), .op_mode(mode),
      .normal_ready(ready), .serial_frame_error(ferr));

   lsi_host_model u_lsi_host_model (
      .ref_clk(ref_clk), .spi_sck(sck), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo));

   task automatic wrap_up();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic chk_byte(input string name, input lsi_byte_t exp, input lsi_byte_t got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_byte

   task automatic chk_bit(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   task automatic reg_wr(input logic [6:0] a, input lsi_byte_t d);
      logic [15:0] rx;
      u_lsi_host_model.xfer({a, 1'b1, d}, 16, rx);
   endtask : reg_wr

   task automatic expect_reg(input string name, input logic [6:0] a, input lsi_byte_t exp);
      logic [15:0] rx;
      u_lsi_host_model.xfer({a, 1'b0, 8'h00}, 16, rx);
      chk_byte(name, exp, rx[7:0]);
   endtask : expect_reg

   // Bounded wait; a hang ends the run at once
   task automatic wait_irq(input logic exp);
      int n;
      n = 0;
      while (irq_n !== exp && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk_bit("irq", exp, irq_n);
      if (irq_n !== exp) wrap_up();
   endtask : wait_irq

   task automatic t_regs();
      logic [15:0] rx;
      expect_reg("mask3", 7'h58, 8'hBC);
      expect_reg("flags", 7'h5A, 8'h00);
      expect_reg("mask4", 7'h5E, 8'hCC);
      reg_wr(7'h58, 8'hFF);
      expect_reg("mask3", 7'h58, 8'hBC);
      reg_wr(7'h5E, 8'h00);
      expect_reg("mask4", 7'h5E, 8'h00);
      reg_wr(7'h5E, 8'hFF);
      expect_reg("mask4", 7'h5E, 8'hCC);
      reg_wr(7'h20, 8'hFF);
      expect_reg("unmapped", 7'h20, 8'h00);
      // A torn frame must not write and must flag itself
      u_lsi_host_model.xfer({7'h5E, 1'b1, 8'h00}, 15, rx);
      expect_reg("mask4", 7'h5E, 8'hCC);
      chk_byte("frame errors", 8'h01, 8'(ferr_seen));
      chk_bit("sdo_oe seen", 1'b1, oe_seen);
      chk_bit("sdo_oe idle", 1'b0, sdo_oe);
   endtask : t_regs

   task automatic t_events();
      reg_wr(7'h5E, 8'h00);
      @(posedge ref_clk);
      ev <= 4'hF;
      repeat (6) @(posedge ref_clk);
      ev <= 4'h0;
      expect_reg("flags", 7'h5A, 8'hCC);
      wait_irq(1'b1);
      reg_wr(7'h5A, 8'h00);
      expect_reg("flags", 7'h5A, 8'hCC);
      reg_wr(7'h5E, 8'h80);
      wait_irq(1'b0);
      reg_wr(7'h5A, 8'h80);
      expect_reg("flags", 7'h5A, 8'h4C);
      wait_irq(1'b1);
      reg_wr(7'h5A, 8'h0C);
      expect_reg("flags", 7'h5A, 8'h40);
      fault3 <= 8'h10;
      wait_irq(1'b0);
      reg_wr(7'h58, 8'h00);
      wait_irq(1'b1);
      fault3 <= 8'h00;
   endtask : t_events

   task automatic t_modes();
      int n;
      mreq   <= LSI_NORMAL;
      mreq_v <= 1'b1;
      lrx    <= 1'b0;
      @(posedge ref_clk);
      mreq_v <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk_bit("rxd parked", 1'b1, rxd);
      n = 0;
      while (ready !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk_bit("ready", 1'b1, ready);
      if (ready !== 1'b1) wrap_up();
      // Host trusts the receive output only once settling is over
      repeat (14) @(posedge ref_clk);
      chk_bit("rxd follows bus", 1'b0, rxd);
      lrx <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk_bit("rxd follows bus", 1'b1, rxd);
      uv <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk_bit("rxd", 1'b0, rxd);
      chk_byte("mode", {6'h00, LSI_STANDBY}, {6'h00, mode});
      uv  <= 1'b0;
      por <= 1'b1;
      repeat (6) @(posedge ref_clk);
      por <= 1'b0;
      repeat (8) @(posedge ref_clk);
      expect_reg("mask3", 7'h58, 8'hBC);
   endtask : t_modes

   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      t_regs();
      t_events();
      t_modes();
      wrap_up();
   end
endmodule : lsi_top_tb_top

`default_nettype wire
